// File: logic/ata_cmd_dev.sv
/*
 * drive end: decodes flush and format commands, runs the cache flush and
 * the media format against a simple media port, posts status and error.
 * assumes the host keeps one command outstanding and waits for done.
 */
// The implementer's own choices: the placing of the registers and the APB slave port.
// How it works
// - opcode E7h is the short cache flush
// - opcode EAh is the extended cache flush
// - flush completes after cache fully committed, or at once on the first failed write
// - failed flush: abort bit, first failed address
// - status bits: fault 5, sense 1, error 0
// - host sends format F7h with feature 11h
// - format aborted unless erase prepare came just before
// - host precedes format with erase prepare
// - format clears every block up to native top
// - merge reassigned list into defects before clearing
// - format has no data phase, status only
// - host times format from identify word 89
// - rejected format: abort bit and error status
`timescale 1ns/10ps
`include "ata_cmd_regs.svh"

module ata_cmd_dev (
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    ata_cmd_if.dev                    link,
    input  wire ata_cmd_pkg::lba_t    highest_native_block_address_i,
    input  wire logic                 cache_dirty_i,
    input  wire logic                 cache_wr_ok_i,
    input  wire logic                 cache_wr_fail_i,
    input  wire ata_cmd_pkg::lba_t    cache_wr_lba_i,
    input  wire logic                 media_fault_i,
    input  wire logic                 sense_pending_i,
    output logic                      cache_wr_req_o,
    output logic                      defect_merge_o,
    output logic                      block_init_o,
    output ata_cmd_pkg::lba_t         block_init_lba_o
);
    ata_cmd_pkg::dev_state_e state;
    logic                    prep_seen;
    logic                    fail;
    ata_cmd_pkg::lba_t       init_lba;
    logic [7:0]              init_cnt;
    logic                    accept;

    assign accept = link.cmd_valid && state == ata_cmd_pkg::DEV_IDLE;

    // erase prepare arms the next command only
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prep_seen <= 1'b0;
        end else if (accept) begin
            prep_seen <= (link.cmd_op == `OP_ERASE_PREP);
        end
    end

    // command engine
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ata_cmd_pkg::DEV_IDLE;
        end else begin
            unique case (state)
            ata_cmd_pkg::DEV_IDLE: begin
                if (accept) begin
                    if (link.cmd_op == `OP_FLUSH28 ||
                        link.cmd_op == `OP_FLUSH48) begin
                        state <= ata_cmd_pkg::DEV_FLUSH;
                    end else if (link.cmd_op == `OP_FORMAT &&
                                 prep_seen) begin
                        state <= ata_cmd_pkg::DEV_MERGE;
                    end else begin
                        state <= ata_cmd_pkg::DEV_POST; // ack or reject
                    end
                end
            end
            ata_cmd_pkg::DEV_FLUSH: begin
                if (cache_wr_fail_i || !cache_dirty_i) begin
                    state <= ata_cmd_pkg::DEV_POST;
                end
            end
            ata_cmd_pkg::DEV_MERGE: begin
                state <= ata_cmd_pkg::DEV_INIT;
            end
            ata_cmd_pkg::DEV_INIT: begin
                if (init_cnt == 8'(`BLOCK_INIT_CYC - 1) &&
                    init_lba == highest_native_block_address_i) begin
                    state <= ata_cmd_pkg::DEV_POST;
                end
            end
            ata_cmd_pkg::DEV_POST: begin
                state <= ata_cmd_pkg::DEV_IDLE;
            end
            endcase
        end
    end

    // failure flag of the command in flight, reloaded while idle: set on accepting a format without erase prepare or on a failed flush write
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fail <= 1'b0;
        end else if (state == ata_cmd_pkg::DEV_IDLE) begin
            fail <= accept && link.cmd_op == `OP_FORMAT &&
                    !prep_seen;
        end else if (state == ata_cmd_pkg::DEV_FLUSH &&
                     cache_wr_fail_i) begin
            fail <= 1'b1;
        end
    end

    // block walk: address and cycles spent on the current block
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            init_lba <= '0;
            init_cnt <= 8'h00;
        end else if (state == ata_cmd_pkg::DEV_MERGE) begin
            init_lba <= '0;
            init_cnt <= 8'h00;
        end else if (state == ata_cmd_pkg::DEV_INIT) begin
            if (init_cnt == 8'(`BLOCK_INIT_CYC - 1)) begin
                init_cnt <= 8'h00;
                if (init_lba != highest_native_block_address_i) begin
                    init_lba <= init_lba + 1'b1;
                end
            end else begin
                init_cnt <= init_cnt + 1'b1;
            end
        end
    end

    // cache write request, dropped at once on a failed write
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cache_wr_req_o <= 1'b0;
        end else begin
            cache_wr_req_o <= state == ata_cmd_pkg::DEV_FLUSH &&
                              cache_dirty_i && !cache_wr_fail_i;
        end
    end

    // one merge pulse ahead of the block walk
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            defect_merge_o <= 1'b0;
        end else begin
            defect_merge_o <= state == ata_cmd_pkg::DEV_MERGE;
        end
    end

    // one init pulse per block with its address
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            block_init_o     <= 1'b0;
            block_init_lba_o <= '0;
        end else begin
            block_init_o     <= state == ata_cmd_pkg::DEV_INIT &&
                                init_cnt == 8'h00;
            block_init_lba_o <= init_lba;
        end
    end

    // completion strobe, one cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link.done <= 1'b0;
        end else begin
            link.done <= state == ata_cmd_pkg::DEV_POST;
        end
    end

    // busy from accept until status is posted
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link.busy <= 1'b0;
        end else if (accept) begin
            link.busy <= 1'b1;
        end else if (state == ata_cmd_pkg::DEV_POST) begin
            link.busy <= 1'b0;
        end
    end

    // address of the first block that could not be written
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link.ret_lba <= '0;
        end else if (state == ata_cmd_pkg::DEV_FLUSH && cache_wr_fail_i) begin
            link.ret_lba <= cache_wr_lba_i;
        end else if (accept) begin
            link.ret_lba <= '0;
        end
    end

    // status and error fields, posted with done
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            link.status <= 8'h00;
            link.error  <= 8'h00;
        end else if (state == ata_cmd_pkg::DEV_POST) begin
            link.status <= 8'h00;
            link.status[`STS_FAULT_BIT] <= media_fault_i;
            link.status[`STS_SENSE_BIT] <= sense_pending_i;
            link.status[`STS_ERROR_BIT] <= fail;
            link.error  <= 8'h00;
            link.error[`ERR_ABORT_BIT]  <= fail;
        end
    end

    // write results are not counted: completion follows the dirty level
    logic unused_ok;
    assign unused_ok = cache_wr_ok_i;
endmodule // ata_cmd_dev

// File: logic/ata_cmd_regs.svh
/*
 * constants of the flush and format command path: opcodes, field bits,
 * host register offsets and timing counts.
 * assumes inclusion by bare name from the package and the design files.
 */
`ifndef ATA_CMD_REGS_SVH
`define ATA_CMD_REGS_SVH

// command opcodes and the format feature value
`define OP_FLUSH28        8'hE7
`define OP_FLUSH48        8'hEA
`define OP_FORMAT         8'hF7
`define OP_ERASE_PREP     8'hF3
`define FORMAT_FEATURE    8'h11

// error field and status field bit positions
`define ERR_ABORT_BIT     2
`define STS_FAULT_BIT     5
`define STS_SENSE_BIT     1
`define STS_ERROR_BIT     0

// host registers, byte offsets on apb
`define REG_CTRL          12'h000
`define REG_CMD           12'h004
`define REG_FEATURE       12'h008
`define REG_ADDR          12'h00C
`define REG_STATUS        12'h010
`define REG_ERROR         12'h014
`define REG_RET_ADDR      12'h018
`define REG_IRQ_STATUS    12'h01C
`define REG_IRQ_MASK      12'h020

// ctrl register: bit 0 writes a one to issue the staged command
`define CTRL_GO_BIT       0
// host status register bits
`define HST_BUSY_BIT      0
`define HST_DONE_BIT      1
// interrupt bits: completion, failed completion
`define IRQ_DONE_BIT      0
`define IRQ_FAIL_BIT      1

// address width of a block address
`define LBA_W             48
// media model timing: cycles per block initialised during format
`define BLOCK_INIT_NS     20
`define CLK_NS            10
`define BLOCK_INIT_CYC    ((`BLOCK_INIT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// File: logic/ata_cmd_pkg.sv
/*
 * types shared by the two ends of the command link.
 * assumes the constants header is on the include path.
 */
`include "ata_cmd_regs.svh"

package ata_cmd_pkg;
    typedef logic [7:0]            byte_t;
    typedef logic [`LBA_W-1:0]     lba_t;

    // device command engine states
    typedef enum logic [4:0] {
        DEV_IDLE   = 5'b00001,
        DEV_FLUSH  = 5'b00010,
        DEV_MERGE  = 5'b00100,
        DEV_INIT   = 5'b01000,
        DEV_POST   = 5'b10000
    } dev_state_e;

    // host controller states
    typedef enum logic [2:0] {
        HOST_IDLE  = 3'b001,
        HOST_ISSUE = 3'b010,
        HOST_WAIT  = 3'b100
    } host_state_e;
endpackage

// File: logic/ata_cmd_if.sv
/*
 * command link between the host controller and the drive command logic.
 * assumes both ends share clk_i; the testbench instantiates and joins it.
 */
`timescale 1ns/10ps

interface ata_cmd_if;
    logic                 cmd_valid; // one-cycle command strobe
    ata_cmd_pkg::byte_t   cmd_op;
    ata_cmd_pkg::byte_t   cmd_feature;
    ata_cmd_pkg::byte_t   cmd_count;
    ata_cmd_pkg::lba_t    cmd_lba;
    logic                 busy;      // device holds one command
    logic                 done;      // one-cycle completion strobe
    ata_cmd_pkg::byte_t   status;
    ata_cmd_pkg::byte_t   error;
    ata_cmd_pkg::lba_t    ret_lba;

    modport host (
        output cmd_valid, cmd_op, cmd_feature, cmd_count, cmd_lba,
        input  busy, done, status, error, ret_lba
    );
    modport dev (
        input  cmd_valid, cmd_op, cmd_feature, cmd_count, cmd_lba,
        output busy, done, status, error, ret_lba
    );
endinterface // ata_cmd_if

// File: logic/ata_cmd_host.sv
/*
 * host end: apb slave with command staging registers, issues one command
 * on the link, collects status and raises a masked interrupt.
 * assumes software follows erase prepare with format and sets feature 11h.
 */
`timescale 1ns/10ps
`include "ata_cmd_regs.svh"

module ata_cmd_host (
    input  wire logic          clk_i,
    input  wire logic          sys_rst_i,
    ata_cmd_if.host            link,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    output logic               irq_o
);
    ata_cmd_pkg::host_state_e state;
    ata_cmd_pkg::byte_t       cmd_reg;
    ata_cmd_pkg::byte_t       feat_reg;
    logic [31:0]              addr_reg;
    ata_cmd_pkg::byte_t       sts_reg;
    ata_cmd_pkg::byte_t       err_reg;
    ata_cmd_pkg::lba_t        ret_reg;
    logic [1:0]               irq_sts;
    logic [1:0]               irq_mask;
    logic                     wr;
    logic                     rd;
    logic                     go;
    logic                     known;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign go = wr && paddr == `REG_CTRL && pwdata[`CTRL_GO_BIT] &&
                state == ata_cmd_pkg::HOST_IDLE;
    assign known = paddr <= `REG_IRQ_MASK && paddr[1:0] == 2'b00;

    // staging registers written by software
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmd_reg  <= 8'h00;
            feat_reg <= 8'h00;
            addr_reg <= 32'h0000_0000;
            irq_mask <= 2'b00;
        end else if (wr) begin
            if (paddr == `REG_CMD) cmd_reg <= pwdata[7:0];
            if (paddr == `REG_FEATURE) feat_reg <= pwdata[7:0];
            if (paddr == `REG_ADDR) addr_reg <= pwdata;
            if (paddr == `REG_IRQ_MASK) irq_mask <= pwdata[1:0];
        end
    end

    // issue one command, then wait for the completion strobe
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state            <= ata_cmd_pkg::HOST_IDLE;
            link.cmd_valid   <= 1'b0;
            link.cmd_op      <= 8'h00;
            link.cmd_feature <= 8'h00;
            link.cmd_count   <= 8'h00;
            link.cmd_lba     <= '0;
        end else begin
            link.cmd_valid <= 1'b0;
            unique case (state)
            ata_cmd_pkg::HOST_IDLE: begin
                if (go && !link.busy) begin
                    link.cmd_valid   <= 1'b1;
                    link.cmd_op      <= cmd_reg;
                    link.cmd_feature <= feat_reg;
                    link.cmd_count   <= 8'h00;
                    link.cmd_lba     <= `LBA_W'(addr_reg);
                    state            <= ata_cmd_pkg::HOST_ISSUE;
                end
            end
            ata_cmd_pkg::HOST_ISSUE: state <= ata_cmd_pkg::HOST_WAIT;
            ata_cmd_pkg::HOST_WAIT: begin
                if (link.done) state <= ata_cmd_pkg::HOST_IDLE;
            end
            endcase
        end
    end

    // capture results and sticky interrupt bits, set wins over clear
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sts_reg <= 8'h00;
            err_reg <= 8'h00;
            ret_reg <= '0;
            irq_sts <= 2'b00;
        end else begin
            if (link.done) begin
                sts_reg <= link.status;
                err_reg <= link.error;
                ret_reg <= link.ret_lba;
            end
            irq_sts <= (irq_sts &
                        ~((wr && paddr == `REG_IRQ_STATUS) ? pwdata[1:0]
                                                           : 2'b00)) |
                       {link.done && link.status[`STS_ERROR_BIT],
                        link.done};
        end
    end

    // apb read data, zero wait states
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            irq_o   <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !known;
            irq_o   <= |(irq_sts & irq_mask);
            if (rd) begin
                unique case (paddr)
                `REG_CMD:        prdata <= {24'h000000, cmd_reg};
                `REG_FEATURE:    prdata <= {24'h000000, feat_reg};
                `REG_ADDR:       prdata <= addr_reg;
                `REG_STATUS:     prdata <= {24'h000000, sts_reg};
                `REG_ERROR:      prdata <= {24'h000000, err_reg};
                `REG_RET_ADDR:   prdata <= ret_reg[31:0];
                `REG_IRQ_STATUS: prdata <= {30'h0, irq_sts};
                `REG_IRQ_MASK:   prdata <= {30'h0, irq_mask};
                `REG_CTRL:       prdata <= {30'h0, link.busy,
                                   state != ata_cmd_pkg::HOST_IDLE};
                default:         prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule // ata_cmd_host

// File: bench/ata_cmd_asserts.sv
/* checker on the command link between host end and drive end.
   assumes one clock, reset active high, signals taken from the link. */
`timescale 1ns/10ps
`include "ata_cmd_regs.svh"

module ata_cmd_asserts (
    input wire logic               clk_i,
    input wire logic               sys_rst_i,
    input wire logic               cmd_valid,
    input wire ata_cmd_pkg::byte_t cmd_op,
    input wire logic               busy,
    input wire logic               done,
    input wire ata_cmd_pkg::byte_t status,
    input wire ata_cmd_pkg::byte_t error
);
    logic pend;
    logic armed;
    logic accept;
    logic fmt;

    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // accepted command and format decode
    assign accept = cmd_valid && !busy;
    assign fmt    = accept && (cmd_op == `OP_FORMAT);

    // one command outstanding from accept to done
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            pend <= 1'b0;
        end else if (accept) begin
            pend <= 1'b1;
        end else if (done) begin
            pend <= 1'b0;
        end
    end

    // erase prepare arms only the next accepted command
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            armed <= 1'b0;
        end else if (accept) begin
            armed <= (cmd_op == `OP_ERASE_PREP);
        end
    end

    AST_DONE_PULSE: assert property (done |=> !done)
        else $error("done held longer than one cycle");
    AST_BUSY_ON_ACCEPT: assert property (accept |=> busy)
        else $error("busy missing after accepted command");
    AST_DONE_HAS_CMD: assert property (done |-> pend)
        else $error("done without outstanding command");
    AST_BUSY_TRACK: assert property (pend && !done |-> busy)
        else $error("busy dropped before completion");
    AST_STATUS_AT_DONE: assert property ($changed(status) |-> done)
        else $error("status changed outside completion");
    AST_ABORT_ERR: assert property (
        done && error[`ERR_ABORT_BIT] |-> status[`STS_ERROR_BIT])
        else $error("abort without error status");
    AST_FMT_REJECT: assert property (
        fmt && !armed |-> ##[1:3] (done && error[`ERR_ABORT_BIT] &&
        status[`STS_ERROR_BIT]))
        else $error("unprepared format not aborted");
    AST_FMT_MIN: assert property (fmt && armed |=> !done [*3])
        else $error("format finished too early");
    AST_FMT_OK: assert property (
        fmt && armed |-> ##[4:1000] (done && !error[`ERR_ABORT_BIT]))
        else $error("prepared format did not complete cleanly");
endmodule // ata_cmd_asserts

// File: bench/cache_flush_and_format_cmds_tb.sv
/* bench: host end and drive end joined, apb scenarios for flush, format.
   assumes package, header and design files are compiled first. */
`timescale 1ns/10ps
`include "ata_cmd_regs.svh"

module cache_flush_and_format_cmds_tb;
    logic              clk_i, sys_rst_i, psel, penable, pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic              pready, pslverr, irq_o, last_err, mask_en, ifail;
    ata_cmd_pkg::lba_t hnba, fail_lba, init_first, init_last, binit_lba;
    logic              dirty, wr_fail, fault, sense, fail_arm, dirty_at_done;
    logic              wr_req, merge, binit;
    int                dirty_cnt, init_cnt, merge_at;
    int                mismatches, samples_checked;
    logic [7:0]        sts, err;

    ata_cmd_if ata_cmd_if_inst ();
    ata_cmd_host ata_cmd_host_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .link(ata_cmd_if_inst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_o(irq_o));
    ata_cmd_dev ata_cmd_dev_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .link(ata_cmd_if_inst), .highest_native_block_address_i(hnba),
        .cache_dirty_i(dirty), .cache_wr_ok_i(1'b0),
        .cache_wr_fail_i(wr_fail), .cache_wr_lba_i(fail_lba),
        .media_fault_i(fault), .sense_pending_i(sense),
        .cache_wr_req_o(wr_req), .defect_merge_o(merge),
        .block_init_o(binit), .block_init_lba_o(binit_lba));
    ata_cmd_asserts ata_cmd_asserts_inst (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .cmd_valid(ata_cmd_if_inst.cmd_valid),
        .cmd_op(ata_cmd_if_inst.cmd_op), .busy(ata_cmd_if_inst.busy),
        .done(ata_cmd_if_inst.done), .status(ata_cmd_if_inst.status),
        .error(ata_cmd_if_inst.error));

    // clock source
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // write cache drains while the drive asks; media init monitor
    assign dirty = (dirty_cnt != 0);
    always @(posedge clk_i) begin
        wr_fail <= 1'b0;
        if (wr_req && dirty_cnt != 0) begin
            dirty_cnt <= dirty_cnt - 1;
            wr_fail <= fail_arm && (dirty_cnt == 2);
        end
        if (ata_cmd_if_inst.done) dirty_at_done <= dirty;
        if (merge) merge_at <= init_cnt;
        if (binit && init_cnt == 0) init_first <= binit_lba;
        if (binit) init_cnt <= init_cnt + 1;
        if (binit) init_last <= binit_lba;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; pready sampled at rising edges, then released
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // issue one command, poll completion, collect results, clear events
    task automatic run_cmd(input logic [7:0] op, input logic [7:0] ft);
        int n;
        apb(1'b1, `REG_CMD, {24'h0, op});
        apb(1'b1, `REG_FEATURE, {24'h0, ft});
        apb(1'b1, `REG_CTRL, 32'h1);
        n = 0;
        do begin
            apb(1'b0, `REG_IRQ_STATUS, 32'h0);
            n++;
        end while (rd[`IRQ_DONE_BIT] !== 1'b1 && n < 200);
        chk(rd[`IRQ_DONE_BIT], 1'b1);
        ifail = rd[`IRQ_FAIL_BIT];
        chk(irq_o, mask_en);
        apb(1'b0, `REG_STATUS, 32'h0);
        sts = rd[7:0];
        apb(1'b0, `REG_ERROR, 32'h0);
        err = rd[7:0];
        chk(ifail, err[`ERR_ABORT_BIT]);
        apb(1'b1, `REG_IRQ_STATUS, 32'h3);
    endtask

    task automatic t_regs();
        apb(1'b0, `REG_IRQ_MASK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk(last_err, 1'b1);
    endtask

    task automatic t_flush();
        logic [7:0] ops [2];
        ops = '{`OP_FLUSH28, `OP_FLUSH48};
        for (int i = 0; i < 2; i++) begin
            dirty_cnt <= 4;
            run_cmd(ops[i], 8'h00);
            chk(dirty_at_done, 1'b0);
            chk(dirty_cnt, 0);
            chk({sts, err}, 16'h0);
            mask_en = 1'b1;
            apb(1'b1, `REG_IRQ_MASK, 32'h3);
        end
        apb(1'b0, `REG_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(irq_o, 1'b0);
        dirty_cnt <= 3;
        run_cmd(8'h00, 8'h00);
        chk(dirty_cnt, 3);
    endtask

    task automatic t_flush_fail();
        fail_arm <= 1'b1;
        fault <= 1'b1;
        sense <= 1'b1;
        dirty_cnt <= 4;
        run_cmd(`OP_FLUSH48, 8'h00);
        chk(err[`ERR_ABORT_BIT], 1'b1);
        chk({sts[`STS_FAULT_BIT], sts[`STS_SENSE_BIT]}, 2'b11);
        chk(sts[`STS_ERROR_BIT], 1'b1);
        chk(ata_cmd_if_inst.ret_lba, fail_lba);
        apb(1'b0, `REG_RET_ADDR, 32'h0);
        chk(rd, fail_lba[31:0]);
        fail_arm <= 1'b0;
        fault <= 1'b0;
        sense <= 1'b0;
    endtask

    task automatic t_format();
        dirty_cnt <= 0;
        run_cmd(`OP_ERASE_PREP, 8'h00);
        run_cmd(`OP_FLUSH28, 8'h00);
        run_cmd(`OP_FORMAT, `FORMAT_FEATURE);
        chk(err[`ERR_ABORT_BIT], 1'b1);
        chk(sts[`STS_ERROR_BIT], 1'b1);
        chk(init_cnt, 0);
        run_cmd(`OP_ERASE_PREP, 8'h00);
        run_cmd(`OP_FORMAT, `FORMAT_FEATURE);
        chk({sts, err}, 16'h0);
        chk(init_cnt, hnba + 1);
        chk(init_first, 48'h0);
        chk(init_last, hnba);
        chk(merge_at, 0);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {fault, sense, fail_arm, mask_en, dirty_at_done} = '0;
        {dirty_cnt, init_cnt, mismatches, samples_checked} = '0;
        merge_at = -1;
        hnba = 48'h7;
        fail_lba = 48'hA501_2345_6789;
        sys_rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_flush();
        t_flush_fail();
        t_format();
        print_verdict();
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        print_verdict();
    end
endmodule // cache_flush_and_format_cmds_tb
